// [common/auts_map.svh]
// Constants for the API serial time-sync port.
// Assumes a 40 MHz system clock; included by its bare name.
`ifndef AUTS_MAP_SVH
`define AUTS_MAP_SVH
`define AUTS_CLK_HZ          40000000
`define AUTS_BAUD_FAST       115200
`define AUTS_BAUD_SLOW       9600
`define AUTS_DIV_FAST        (`AUTS_CLK_HZ / `AUTS_BAUD_FAST)
`define AUTS_DIV_SLOW        (`AUTS_CLK_HZ / `AUTS_BAUD_SLOW)
`define AUTS_TX_GAP_US       100
`define AUTS_TX_GAP_CYC      ((`AUTS_TX_GAP_US * (`AUTS_CLK_HZ / 1000000)))
`define AUTS_IDLE_BITS       20
`define AUTS_MODE2_CODE      3'h2
`define AUTS_MODE4_CODE      3'h4
`define AUTS_FLAG_BYTE       8'h7e
`define AUTS_ESC_BYTE        8'h7d
`define AUTS_ESC_XOR         8'h20
`define AUTS_TIME_CMD        8'h0d
`define AUTS_FIFO_DEPTH      4
`define AUTS_STAMP_W         32
`endif

// [common/auts_pkg.sv]
// Types shared by the API serial time-sync port.
// Assumes the map header supplies the numeric constants.
`include "auts_map.svh"
package auts_pkg;
    typedef enum logic [1:0] {
        AUTS_RX_IDLE = 2'b00,
        AUTS_RX_OPEN = 2'b01,
        AUTS_RX_DRAIN = 2'b10
    } auts_rx_st_t;
    typedef enum logic [2:0] {
        AUTS_TX_IDLE = 3'b000,
        AUTS_TX_ASK  = 3'b001,
        AUTS_TX_SEND = 3'b010,
        AUTS_TX_WAIT = 3'b011,
        AUTS_TX_GAP  = 3'b100
    } auts_tx_st_t;
    typedef struct packed {
        logic       data_valid;
        logic [7:0] data;
    } auts_byte_t;
    typedef struct packed {
        logic                    req;
        logic [`AUTS_STAMP_W-1:0] stamp;
    } auts_time_t;
endpackage : auts_pkg

// [hdl/auts_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/10ps
module auts_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_ent
            always_ff @(posedge clk) begin
                if (push && wr_ptr == AW'(i)) begin
                    mem[i] <= in_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : auts_fifo

// [hdl/auts_port.sv]
// API serial port with handshakes, activity wake and hardware time capture.
// Assumes synchronous pins, 40 MHz clock, fuse mode word stable at reset release.
// How it works
// RULE1 - Time packet on read request or strobe
// RULE2 - Latch timestamp at strobe rising edge
// RULE3 - Request-driven capture happens after packet processing
// RULE4 - Sleep idle, awake only while data moves; awake also stays high while waiting for clear and in the interpacket gap
// RULE5 - Receive uses request in, clear out
// RULE6 - Transmit uses request out, clear in
// RULE7 - Only mode 2 and mode 4 supported
// RULE8 - Everything runs from one system clock
// RULE9 - Wake purely on interface activity
// RULE10 - Free-running time base counts always
// RULE11 - Mode 2 receive request/clear handshake
// RULE12 - Mode 2 transmit waits clear falling edge
// RULE13 - Mode 4 level clear, interpacket gap
// RULE14 - HDLC framing, 8N1, two baud rates; transmit sends the stamp bytes without escaping, only receive undoes escapes
// RULE15 - Fuse mode read once after reset
// RULE16 - Synchronised strobe, one capture per edge
`timescale 1ns/10ps
module auts_port
    import auts_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Configuration
    input  wire logic [2:0] fuse_mode,
    input  wire logic       fast_baud,
    // Serial lines
    input  wire logic       rx_line,
    output logic            tx_line,
    // Handshakes
    input  wire logic       rx_request_n,
    output logic            rx_clear_n,
    output logic            tx_request_n,
    input  wire logic       tx_clear_n,
    // Time strobe and status
    input  wire logic       time_strobe_n,
    output logic            awake,
    output logic            mode_bad,
    output logic [31:0]     last_stamp
);
    typedef struct packed {
        logic        mode_loaded;
        logic        mode4;
        logic        bad;
        logic [1:0]  strobe_sync;
        logic        strobe_prev;
        logic [31:0] time_base;
        logic [31:0] stamp;
        logic        time_pend;
        auts_rx_st_t rx_st;
        logic        rx_clear_n;
        logic [15:0] rx_div;
        logic [3:0]  rx_bit;
        logic [7:0]  rx_shift;
        logic        rx_busy;
        logic        rx_esc;
        logic        rx_cmd_seen;
        logic        rx_prev;
        auts_tx_st_t tx_st;
        logic        tx_request_n;
        logic        clr_prev;
        logic [2:0]  tx_idx;
        logic [2:0]  tx_cnt;
        logic [15:0] tx_div;
        logic [3:0]  tx_bit;
        logic [9:0]  tx_frame;
        logic        tx_busy;
        logic        tx_line;
        logic        tx_esc_pend;
        logic [31:0] gap_cnt;
        logic        awake;
    } st_t;
    st_t cur, next_cur;

    // Time packet bytes into the FIFO, drained by the serialiser
    logic       f_in_valid;
    logic       f_in_ready;
    logic [7:0] f_in_data;
    logic       f_out_valid;
    logic       f_out_ready;
    logic [7:0] f_out_data;
    logic [15:0] div;

    auts_fifo #(.WIDTH(8), .DEPTH(`AUTS_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    assign div = fast_baud ? 16'(`AUTS_DIV_FAST) : 16'(`AUTS_DIV_SLOW); // [RULE14]

    // Packet layout: flag, command, stamp msb..lsb, flag (7 bytes)
    always_comb begin
        case (cur.tx_idx)
            3'h0:    f_in_data = `AUTS_FLAG_BYTE;
            3'h1:    f_in_data = `AUTS_TIME_CMD;
            3'h2:    f_in_data = cur.stamp[31:24];
            3'h3:    f_in_data = cur.stamp[23:16];
            3'h4:    f_in_data = cur.stamp[15:8];
            3'h5:    f_in_data = cur.stamp[7:0];
            default: f_in_data = `AUTS_FLAG_BYTE;
        endcase
    end
    assign f_in_valid  = cur.time_pend && (cur.tx_idx <= 3'h6);
    // Stop after seven bytes so a queued packet waits for its own handshake
    assign f_out_ready = (cur.tx_st == AUTS_TX_SEND) && !cur.tx_busy && (cur.tx_cnt != 3'h7);

    always_comb begin
        next_cur = cur;
        next_cur.time_base = cur.time_base + 32'h1; // [RULE8] [RULE10]
        if (!cur.mode_loaded) begin
            next_cur.mode_loaded = 1'b1; // [RULE15]
            next_cur.mode4 = (fuse_mode == `AUTS_MODE4_CODE); // [RULE7]
            next_cur.bad = (fuse_mode != `AUTS_MODE4_CODE) &&
                           (fuse_mode != `AUTS_MODE2_CODE);
        end
        next_cur.strobe_sync = {cur.strobe_sync[0], time_strobe_n}; // [RULE16]
        next_cur.strobe_prev = cur.strobe_sync[1];
        if (cur.strobe_sync[1] && !cur.strobe_prev && !cur.time_pend) begin
            next_cur.stamp     = cur.time_base; // [RULE2] [RULE16]
            next_cur.time_pend = 1'b1; // [RULE1]
            next_cur.tx_idx    = 3'h0;
        end
        // Receiver with mode 2 handshake
        next_cur.rx_prev = rx_line;
        case (cur.rx_st)
            AUTS_RX_IDLE: begin
                next_cur.rx_clear_n = 1'b1;
                if (!rx_request_n && !cur.mode4) begin
                    next_cur.rx_st      = AUTS_RX_OPEN; // [RULE5] [RULE11]
                    next_cur.rx_clear_n = 1'b0;
                end else if (cur.mode4 && (cur.rx_busy || (cur.rx_prev && !rx_line))) begin
                    next_cur.rx_st = AUTS_RX_OPEN; // [RULE9]
                end
            end
            AUTS_RX_OPEN: begin
                if (!cur.mode4 && rx_request_n && !cur.rx_busy) begin
                    next_cur.rx_st = AUTS_RX_DRAIN; // [RULE11]
                end else if (cur.mode4 && !cur.rx_busy) begin
                    // Mode 4 sleeps again as soon as a byte is in
                    next_cur.rx_st = AUTS_RX_DRAIN;
                end
            end
            AUTS_RX_DRAIN: begin
                next_cur.rx_clear_n = 1'b1; // [RULE11]
                next_cur.rx_st      = AUTS_RX_IDLE;
            end
            default: next_cur.rx_st = AUTS_RX_IDLE;
        endcase
        // Mode 4 has no receive handshake, so the receiver always listens
        if (cur.rx_st != AUTS_RX_IDLE || cur.mode4) begin
            if (!cur.rx_busy) begin
                if (cur.rx_prev && !rx_line) begin
                    next_cur.rx_busy = 1'b1;
                    next_cur.rx_div  = {1'b0, div[15:1]};
                    next_cur.rx_bit  = 4'h0;
                end
            end else if (cur.rx_div != 16'h0) begin
                next_cur.rx_div = cur.rx_div - 16'h1;
            end else begin
                next_cur.rx_div = div - 16'h1;
                next_cur.rx_bit = cur.rx_bit + 4'h1;
                if (cur.rx_bit >= 4'h1 && cur.rx_bit <= 4'h8) begin
                    next_cur.rx_shift = {rx_line, cur.rx_shift[7:1]};
                end
                if (cur.rx_bit == 4'h9) begin
                    next_cur.rx_busy = 1'b0; // [RULE14]
                    if (cur.rx_shift == `AUTS_ESC_BYTE) begin
                        next_cur.rx_esc = 1'b1;
                    end else if (cur.rx_shift == `AUTS_FLAG_BYTE) begin
                        next_cur.rx_esc = 1'b0;
                        if (cur.rx_cmd_seen && !cur.time_pend) begin
                            next_cur.stamp     = cur.time_base; // [RULE3] [RULE1]
                            next_cur.time_pend = 1'b1;
                            next_cur.tx_idx    = 3'h0;
                        end
                        next_cur.rx_cmd_seen = 1'b0;
                    end else begin
                        next_cur.rx_esc = 1'b0;
                        if ((cur.rx_esc ? (cur.rx_shift ^ `AUTS_ESC_XOR) : cur.rx_shift)
                            == `AUTS_TIME_CMD) begin
                            next_cur.rx_cmd_seen = 1'b1;
                        end
                    end
                end
            end
        end else begin
            next_cur.rx_busy = 1'b0;
        end
        // Stuff time packet bytes into the FIFO
        if (f_in_valid && f_in_ready) begin
            next_cur.tx_idx = cur.tx_idx + 3'h1;
        end
        // Transmit handshake
        next_cur.clr_prev = tx_clear_n;
        case (cur.tx_st)
            AUTS_TX_IDLE: begin
                if (f_out_valid) begin
                    next_cur.tx_request_n = 1'b0; // [RULE6]
                    next_cur.tx_st        = AUTS_TX_ASK;
                end
            end
            AUTS_TX_ASK: begin
                if (cur.mode4 ? !tx_clear_n : (cur.clr_prev && !tx_clear_n)) begin
                    next_cur.tx_st  = AUTS_TX_SEND; // [RULE12] [RULE13]
                    next_cur.tx_cnt = 3'h0;
                end
            end
            AUTS_TX_SEND: begin
                if (!cur.tx_busy && cur.tx_cnt == 3'h7) begin
                    next_cur.tx_request_n = 1'b1;
                    next_cur.gap_cnt      = 32'(`AUTS_TX_GAP_CYC);
                    next_cur.tx_st = cur.mode4 ? AUTS_TX_GAP : AUTS_TX_WAIT;
                end
            end
            AUTS_TX_WAIT: begin
                if (tx_clear_n) begin
                    next_cur.tx_st = AUTS_TX_IDLE; // [RULE12]
                end
            end
            AUTS_TX_GAP: begin
                if (cur.gap_cnt == 32'h0) begin
                    next_cur.tx_st = AUTS_TX_IDLE; // [RULE13]
                end else begin
                    next_cur.gap_cnt = cur.gap_cnt - 32'h1;
                end
            end
            default: next_cur.tx_st = AUTS_TX_IDLE;
        endcase
        if (cur.time_pend && cur.tx_idx == 3'h6 && f_in_ready) begin
            next_cur.time_pend = 1'b0;
        end
        // Serialiser, stop bit high, no parity
        if (f_out_ready && f_out_valid) begin
            next_cur.tx_busy  = 1'b1;
            next_cur.tx_frame = {1'b1, f_out_data, 1'b0}; // [RULE14]
            next_cur.tx_bit   = 4'h0;
            next_cur.tx_div   = div - 16'h1;
            next_cur.tx_line  = 1'b0;
            next_cur.tx_cnt   = cur.tx_cnt + 3'h1;
        end else if (cur.tx_busy) begin
            if (cur.tx_div != 16'h0) begin
                next_cur.tx_div = cur.tx_div - 16'h1;
            end else if (cur.tx_bit == 4'h9) begin
                next_cur.tx_busy = 1'b0;
                next_cur.tx_line = 1'b1;
            end else begin
                next_cur.tx_div  = div - 16'h1;
                next_cur.tx_bit  = cur.tx_bit + 4'h1;
                next_cur.tx_line = cur.tx_frame[cur.tx_bit + 4'h1];
            end
        end
        next_cur.awake = (cur.rx_st != AUTS_RX_IDLE) || (cur.tx_st != AUTS_TX_IDLE)
                         || cur.time_pend || f_out_valid; // [RULE4] [RULE9]
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cur              <= '0;
            cur.strobe_sync  <= 2'b11;
            cur.strobe_prev  <= 1'b1;
            cur.rx_st        <= AUTS_RX_IDLE;
            cur.rx_clear_n   <= 1'b1;
            cur.rx_prev      <= 1'b1;
            cur.tx_st        <= AUTS_TX_IDLE;
            cur.tx_request_n <= 1'b1;
            cur.clr_prev     <= 1'b1;
            cur.tx_line      <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign tx_line      = cur.tx_line;
    assign rx_clear_n   = cur.rx_clear_n;
    assign tx_request_n = cur.tx_request_n;
    assign awake        = cur.awake;
    assign mode_bad     = cur.bad;
    assign last_stamp   = cur.stamp;
endmodule : auts_port

// [tb/auts_host.sv]
// Companion processor model facing the API serial port.
// Assumes 115200 baud on a 40 MHz clock; driven by the bench through its tasks.
`timescale 1ns/10ps
`include "auts_map.svh"
module auts_host (
    // Clock
    input  wire logic clk,
    // Device side
    input  wire logic tx_line,
    input  wire logic tx_request_n,
    input  wire logic rx_clear_n,
    // Host side
    output logic      rx_line,
    output logic      rx_request_n,
    output logic      tx_clear_n
);
    localparam int DIV = `AUTS_DIV_FAST;
    initial begin
        rx_line      = 1'b1;
        rx_request_n = 1'b1;
        tx_clear_n   = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Start bit, data LSB first, one stop bit
    task automatic put(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line = f[i];
            tick(DIV);
        end
    endtask : put
    task automatic get(output logic [7:0] b, output bit ok);
        int w;
        w = 0;
        while (tx_line !== 1'b0 && w < 30000) begin
            tick(1);
            w++;
        end
        tick(DIV / 2);
        ok = (w < 30000) && (tx_line === 1'b0);
        for (int i = 0; i < 8; i++) begin
            tick(DIV);
            b[i] = tx_line;
        end
        tick(DIV);
        ok = ok && (tx_line === 1'b1);
    endtask : get
    // Whole packet inside one request, then wait for clear to go high again
    task automatic request_time(output bit ok);
        int w;
        rx_request_n = 1'b0;
        for (w = 0; w < 20 && rx_clear_n !== 1'b0; w++) tick(1);
        ok = (w < 20);
        put(`AUTS_FLAG_BYTE);
        put(`AUTS_TIME_CMD);
        put(`AUTS_FLAG_BYTE);
        rx_request_n = 1'b1;
        for (w = 0; w < 20 && rx_clear_n !== 1'b1; w++) tick(1);
        ok = ok && (w < 20);
    endtask : request_time
endmodule : auts_host

// [tb/auts_port_chk.sv]
// Concurrent checks on the API serial port pins.
// Assumes one clock domain and a synchronous active-low reset; bound below.
`timescale 1ns/10ps
`include "auts_map.svh"
module auts_port_chk
    import auts_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Configuration
    input  wire logic [2:0]  fuse_mode,
    input  wire logic        fast_baud,
    // Serial lines
    input  wire logic        rx_line,
    input  wire logic        tx_line,
    // Handshakes
    input  wire logic        rx_request_n,
    input  wire logic        rx_clear_n,
    input  wire logic        tx_request_n,
    input  wire logic        tx_clear_n,
    // Time strobe and status
    input  wire logic        time_strobe_n,
    input  wire logic        awake,
    input  wire logic        mode_bad,
    input  wire logic [31:0] last_stamp
);
    localparam int GAP = `AUTS_TX_GAP_CYC - 1;
    logic        first, m4, bad, armed, clr_q, req_q;
    logic [12:0] gap;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Mode copy, clear-fall arming and interpacket count
    always_ff @(posedge clk) begin
        clr_q <= tx_clear_n;
        req_q <= tx_request_n;
        if (!reset_n) begin
            first <= 1'b1;
            m4    <= 1'b0;
            bad   <= 1'b0;
            armed <= 1'b0;
            gap   <= '0;
        end else begin
            first <= 1'b0;
            if (first) begin
                m4  <= (fuse_mode == `AUTS_MODE4_CODE);
                bad <= !(fuse_mode == `AUTS_MODE4_CODE || fuse_mode == `AUTS_MODE2_CODE);
            end
            armed <= !tx_request_n && (armed || (clr_q && !tx_clear_n));
            if (!tx_request_n) gap <= '0;
            else if (!req_q) gap <= 13'h1;
            else if (gap != '0 && gap < 13'(GAP)) gap <= gap + 13'h1;
        end
    end
    a_reset_idle: assert property ($rose(reset_n) |-> tx_line && rx_clear_n && tx_request_n
        && !awake && !mode_bad && last_stamp == '0) else $error("outputs not idle after reset");
    a_rx_answer: assert property (!m4 && !first && $fell(rx_request_n) && rx_clear_n
        |-> ##[1:2] !rx_clear_n) else $error("receive clear not given");
    a_rx_hold: assert property (!m4 && !rx_clear_n && !rx_request_n |=> !rx_clear_n)
        else $error("receive clear dropped while requested");
    a_m4_noclear: assert property (m4 && !first |-> rx_clear_n)
        else $error("receive clear driven in mode 4");
    a_tx_waits: assert property (!m4 && !first && !armed |-> tx_line)
        else $error("transmit before clear falling edge");
    a_m4_gap: assert property (m4 && gap != '0 && gap < 13'(GAP) |-> tx_request_n)
        else $error("interpacket gap too short");
    a_stamp_edge: assert property ($rose(time_strobe_n) && !awake
        |-> ##[2:6] !$stable(last_stamp)) else $error("strobe edge not captured");
    a_one_capture: assert property (!$stable(last_stamp) |=> $stable(last_stamp) [*8])
        else $error("stamp captured twice");
    a_cap_request: assert property (!$stable(last_stamp) && tx_clear_n
        |-> ##[0:8] !tx_request_n) else $error("no time packet after capture");
    a_awake_tx: assert property (!tx_line [*2] |-> awake)
        else $error("sending while asleep");
    a_mode_flag: assert property (!first |-> mode_bad == bad)
        else $error("mode flag wrong");
    c_tx_req: cover property ($fell(tx_request_n));
    c_rx_open: cover property (!m4 && $fell(rx_clear_n));
    c_gap_end: cover property (m4 && gap == 13'(GAP - 1));
endmodule : auts_port_chk
bind auts_port auts_port_chk u_chk (.clk(clk), .reset_n(reset_n), .fuse_mode(fuse_mode),
    .fast_baud(fast_baud), .rx_line(rx_line), .tx_line(tx_line), .rx_request_n(rx_request_n),
    .rx_clear_n(rx_clear_n), .tx_request_n(tx_request_n), .tx_clear_n(tx_clear_n),
    .time_strobe_n(time_strobe_n), .awake(awake), .mode_bad(mode_bad), .last_stamp(last_stamp));

// [tb/auts_port_tb.sv]
// Self-checking bench for the API serial port; its FIFO is driven through the port.
// Assumes the host model in auts_host.sv and the checker bound to auts_port.
`timescale 1ns/10ps
`include "auts_map.svh"
module auts_port_tb;
    import auts_pkg::*;
    logic        clk, reset_n, fast_baud, time_strobe_n, awake, mode_bad;
    logic [2:0]  fuse_mode;
    logic        rx_line, rx_request_n, rx_clear_n, tx_line, tx_request_n, tx_clear_n;
    logic [31:0] last_stamp;
    int          n_errors = 0, checks_done = 0, cyc = 0;
    auts_port dut (.clk(clk), .reset_n(reset_n), .fuse_mode(fuse_mode), .fast_baud(fast_baud),
        .rx_line(rx_line), .tx_line(tx_line), .rx_request_n(rx_request_n),
        .rx_clear_n(rx_clear_n), .tx_request_n(tx_request_n), .tx_clear_n(tx_clear_n),
        .time_strobe_n(time_strobe_n), .awake(awake), .mode_bad(mode_bad),
        .last_stamp(last_stamp));
    auts_host h (.clk(clk), .tx_line(tx_line), .tx_request_n(tx_request_n),
        .rx_clear_n(rx_clear_n), .rx_line(rx_line), .rx_request_n(rx_request_n),
        .tx_clear_n(tx_clear_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc++;
    task automatic test_done();
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_req(input int n);
        for (int w = 0; w < n && tx_request_n !== 1'b0; w++) h.tick(1);
    endtask : wait_req
    task automatic do_reset(input logic [2:0] m);
        reset_n   = 1'b0;
        fuse_mode = m;
        h.tick(2);
        reset_n = 1'b1;
        h.tick(2);
        chk({tx_line, rx_clear_n, tx_request_n, awake}, 32'h0e);
        chk(last_stamp, 32'h0);
    endtask : do_reset
    task automatic strobe(output int c);
        time_strobe_n = 1'b0;
        h.tick(4);
        time_strobe_n = 1'b1;
        c = cyc;
        h.tick(8);
    endtask : strobe
    task automatic get_pkt(output logic [31:0] s);
        logic [7:0] b [7];
        bit         ok;
        for (int i = 0; i < 7; i++) begin
            h.get(b[i], ok);
            chk(32'(ok), 32'h1);
        end
        chk(b[0], `AUTS_FLAG_BYTE);
        chk(b[1], `AUTS_TIME_CMD);
        chk(b[6], `AUTS_FLAG_BYTE);
        s = {b[2], b[3], b[4], b[5]};
    endtask : get_pkt
    // Mode 2 transmit; fuse word changed after reset must not matter
    // FIFO fills to depth while clear is withheld, then drains in order
    task automatic t_m2();
        int          c1, c2;
        logic [31:0] s1;
        do_reset(`AUTS_MODE2_CODE);
        fuse_mode    = `AUTS_MODE4_CODE;
        h.tx_clear_n = 1'b0;
        strobe(c1);
        h.tick(600);
        chk(tx_request_n, 1'b0);
        chk(tx_line, 1'b1);
        h.tx_clear_n = 1'b1;
        h.tick(2);
        h.tx_clear_n = 1'b0;
        get_pkt(s1);
        chk(s1, last_stamp);
        h.tick(300);
        chk(tx_request_n, 1'b1);
        strobe(c2);
        chk(last_stamp - s1, 32'(c2 - c1));
        h.tick(50);
        chk(tx_request_n, 1'b1);
        h.tx_clear_n = 1'b1;
        wait_req(50);
        chk(tx_request_n, 1'b0);
    endtask : t_m2
    // Read-time request over the receive path, then sleep
    task automatic t_rx();
        bit          ok;
        logic [31:0] s;
        do_reset(`AUTS_MODE2_CODE);
        h.tx_clear_n = 1'b1;
        h.request_time(ok);
        chk(32'(ok), 32'h1);
        wait_req(400);
        chk(tx_request_n, 1'b0);
        h.tx_clear_n = 1'b0;
        get_pkt(s);
        chk(s, last_stamp);
        h.tx_clear_n = 1'b1;
        h.tick(400);
        chk(awake, 1'b0);
    endtask : t_rx
    // Level clear, ignored receive request, interpacket gap
    task automatic t_m4();
        int          c;
        logic [31:0] s;
        do_reset(`AUTS_MODE4_CODE);
        chk(mode_bad, 1'b0);
        h.tx_clear_n   = 1'b0;
        h.rx_request_n = 1'b0;
        h.tick(10);
        chk(rx_clear_n, 1'b1);
        h.rx_request_n = 1'b1;
        h.rx_line      = 1'b0;
        h.tick(4);
        chk(awake, 1'b1);
        h.rx_line      = 1'b1;
        h.tick(3400);
        chk(awake, 1'b0);
        strobe(c);
        get_pkt(s);
        chk(s, last_stamp);
        strobe(c);
        h.tick(3900);
        chk(tx_request_n, 1'b1);
        wait_req(600);
        chk(tx_request_n, 1'b0);
        h.tx_clear_n = 1'b1;
        do_reset(3'h3);
        chk(mode_bad, 1'b1);
    endtask : t_m4
    // Slow rate: start bit still low long after a fast frame would be past bit 4
    task automatic t_slow();
        int c;
        do_reset(`AUTS_MODE4_CODE);
        fast_baud    = 1'b0;
        h.tx_clear_n = 1'b0;
        strobe(c);
        for (int w = 0; w < 20 && tx_line !== 1'b0; w++) h.tick(1);
        h.tick(2000);
        chk(tx_line, 1'b0);
        h.tx_clear_n = 1'b1;
    endtask : t_slow
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        test_done();
    end
    initial begin
        reset_n       = 1'b0;
        fuse_mode     = `AUTS_MODE2_CODE;
        fast_baud     = 1'b1;
        time_strobe_n = 1'b1;
        t_m2();
        t_rx();
        t_m4();
        t_slow();
        test_done();
    end
endmodule : auts_port_tb
